/* File: design/sre_defines.svh */
// Constants for the serial RAM expansion interface.
// Assumes inclusion by bare name from design files.
`ifndef SRE_DEFINES_SVH
`define SRE_DEFINES_SVH

`define SRE_HDR_BITS      4'h9
`define SRE_HDR_LAST      4'h8
`define SRE_CNT_LAST      6'h3f
`define SRE_HDR_RESET     9'h000
`define SRE_CNT_RESET     6'h00
`define SRE_CNT_STEP      6'h01
`define SRE_HCNT_RESET    4'h0
`define SRE_HCNT_STEP     4'h1
`define SRE_PH_RESET      2'h0
`define SRE_PH_STEP       2'h1
`define SRE_PH_PRE        2'h2
`define SRE_PH_LAST       2'h3
`define SRE_CODE_IDLE     4'h0
`define SRE_HB_RW         8
`define SRE_HB_SEL_HI     7
`define SRE_HB_SEL_LO     4
`define SRE_HB_REG_HI     3
`define SRE_HB_REG_LO     0

`endif

/* File: design/sre_pkg.sv */
// Types shared by the serial RAM expansion interface.
// Assumes the defines header sits beside it.
package sre_pkg;
	typedef enum logic [1:0] {
		SRE_IDLE,
		SRE_HEADER,
		SRE_DATA
	} sre_state_type;
	typedef logic [3:0] sre_nibble_type;
	typedef logic [9:0] sre_addr_type;
endpackage

/* File: design/sre_buf.sv */
// Two-entry valid/ready buffer for single data bits.
// Assumes one clock, asynchronous active low reset.
`timescale 1ns/10ps
`default_nettype none
module sre_buf (
	// Clock and reset
	input  wire logic sys_clk_in,
	input  wire logic rst_n_in,
	input  wire logic flush_in,
	// Fill side
	input  wire logic in_valid_in,
	input  wire logic in_data_in,
	output logic      in_ready_out,
	// Drain side
	output logic      out_valid_out,
	output logic      out_data_out,
	input  wire logic out_ready_in
);
	logic [1:0] data_reg;
	logic [1:0] cnt_reg;
	logic [1:0] cnt_next;
	wire        push = in_valid_in & in_ready_out;
	wire        pop  = out_valid_out & out_ready_in;

	assign in_ready_out  = (cnt_reg != 2'h2);
	assign out_valid_out = (cnt_reg != 2'h0);
	assign out_data_out  = data_reg[0];
	assign cnt_next      = cnt_reg + {1'b0, push} - {1'b0, pop};

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_reg  <= 2'h0;
			data_reg <= 2'h0;
		end else if (flush_in) begin
			cnt_reg  <= 2'h0;
		end else begin
			cnt_reg <= cnt_next;
			if (pop)
				data_reg[0] <= data_reg[1];
			if (push)
				data_reg[(cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop)) ? 0 : 1] <= in_data_in;
		end
	end
endmodule
`default_nettype wire

/* File: design/sre_core.sv */
// Serial RAM expansion interface: header shift, bit counter, RAM drive.
// Assumes host moves data on bit phase marked by sync; inputs synchronous.
//
// Operation
// (R1) Reset clears every register, ready for a new header.
// (R2) Nine-stage header register plus six-bit incrementing counter hold the access.
// (R3) Host shifts sync bit, mode bit, four select bits, four register bits.
// (R4) Header sync bit is always a one.
// (R5) Counter steps all 64 positions, one per bit time.
// (R6) Write mode passes serial input bits to RAM write data; here select is active high, so the OR holds write data at one while selected.
// (R7) Read mode captures RAM bits, buffers them, shifts them to host.
// (R8) After the 64th position header register, counter and state clear.
// (R9) Drives four external 1024 by 1 RAMs directly.
// (R10) RAM select bits from header drive select code outputs.
// (R11) Host holds select active around all serial data, about 75 bits.
// (R12) RAM write data is select OR serial data input.
// (R13) Host toggles select once after power-up before first transfer.
// (R14) Sync marks one oscillator cycle in four as the bit phase.
// (R15) More devices may be added on their own decoded selects.
// (R16) RAM address is register bits above six counter bits.
// (R17) Write strobe pulses per bit in write mode; chip enable spans sequence.
`timescale 1ns/10ps
`default_nettype none
`include "sre_defines.svh"
module sre_core (
	// Clock and reset
	input  wire logic             sys_clk_in,
	input  wire logic             rst_n_in,
	// Host link
	input  wire logic             sync_in,
	input  wire logic             select_in,
	input  wire logic             serial_data_in,
	output logic                  serial_data_out,
	// RAM side
	output sre_pkg::sre_addr_type ram_address_out,
	output sre_pkg::sre_nibble_type ram_select_code_out,
	output logic                  ram_write_data_out,
	input  wire logic             ram_read_data_in,
	output logic                  ram_write_strobe_out,
	output logic                  ram_chip_enable_out,
	output logic                  backup_ram_control_out,
	output logic                  busy_out
);
	import sre_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	sre_state_type state_reg;
	sre_state_type state_next;
	logic [3:0]    hcnt_reg;
	logic [3:0]    hcnt_next;
	logic [5:0]    count_reg;
	logic [5:0]    count_next;
	logic [1:0]    phase_reg;
	logic [1:0]    phase_next;
	logic          sel_valid_reg;
	logic          sel_last_reg;
	logic          sel_seen_reg;
	logic          sel_seen_next;
	logic          out_reg;
	logic          out_next;
	logic          wstb_reg;
	logic          wstb_next;
	wire  [8:0]    header_bits;
	wire  [9:0]    hdr_chain;
	wire           drain_ready;
	wire           buf_valid;
	wire           buf_data;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	// Four-bit header field, counted from its low bit
	function automatic sre_nibble_type hdr_field(input logic [8:0] hdr,
		input int unsigned lo);
		hdr_field = hdr[lo +: $bits(sre_nibble_type)];
	endfunction

	// True while the machine sits in the given state
	function automatic logic in_state(input sre_state_type cur,
		input sre_state_type want);
		in_state = (cur == want);
	endfunction

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Bit phase tied to sync; one bit every four clocks
	wire in_idle    = in_state(state_reg, SRE_IDLE);
	wire in_header  = in_state(state_reg, SRE_HEADER);
	wire in_data    = in_state(state_reg, SRE_DATA);
	wire bit_tick   = (phase_reg == `SRE_PH_LAST); // R14
	// Strobe is launched one clock early so it stands while the address does
	wire pre_tick   = (phase_reg == `SRE_PH_PRE);
	wire write_mode = ~header_bits[`SRE_HB_RW];
	wire hdr_done   = in_header & bit_tick & (hcnt_reg == `SRE_HDR_LAST);
	wire seq_end    = in_data & bit_tick & (count_reg == `SRE_CNT_LAST);
	// History is primed first, so a select held high through reset is no toggle
	wire sel_edge   = sel_valid_reg & (sel_last_reg != select_in);
	wire armed      = sel_seen_reg & select_in; // R13
	wire start_bit  = in_idle & armed & bit_tick & serial_data_in; // R4
	wire abort      = in_header & ~select_in;
	wire hdr_shift  = in_header & bit_tick;
	wire hdr_clear  = (state_next == SRE_IDLE);
	wire cnt_step   = in_data & bit_tick;
	wire rd_take    = in_data & bit_tick & ~write_mode;
	wire wr_pulse   = in_data & pre_tick & write_mode;

	assign hdr_chain   = {header_bits, serial_data_in};
	// Read data leaves the buffer on the next bit tick
	assign drain_ready = bit_tick;

	// ----------------------------------------
	// Sequence control
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			SRE_IDLE: begin
				if (start_bit)
					state_next = SRE_HEADER; // R3
			end
			SRE_HEADER: begin
				if (abort)
					state_next = SRE_IDLE; // R11
				else if (hdr_done)
					state_next = SRE_DATA;
			end
			SRE_DATA: begin
				if (seq_end)
					state_next = SRE_IDLE; // R8
			end
			// Fourth code is unused; fall back to idle
			default: state_next = SRE_IDLE;
		endcase
	end

	// ----------------------------------------
	// Next values
	// ----------------------------------------
	assign phase_next    = sync_in ? `SRE_PH_RESET : phase_reg + `SRE_PH_STEP; // R14
	assign hcnt_next     = hdr_clear ? `SRE_HCNT_RESET :
		(hdr_shift ? hcnt_reg + `SRE_HCNT_STEP : hcnt_reg);
	assign count_next    = hdr_clear ? `SRE_CNT_RESET :
		(cnt_step ? count_reg + `SRE_CNT_STEP : count_reg); // R5 R8
	assign sel_seen_next = sel_seen_reg | sel_edge; // R13
	assign wstb_next     = wr_pulse; // R17
	assign out_next      = (buf_valid & drain_ready) ? buf_data : out_reg; // R7

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= SRE_IDLE; // R1
			hcnt_reg  <= `SRE_HCNT_RESET;
			count_reg <= `SRE_CNT_RESET;
			phase_reg <= `SRE_PH_RESET;
		end else begin
			state_reg <= state_next;
			hcnt_reg  <= hcnt_next;
			count_reg <= count_next; // R2
			phase_reg <= phase_next;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sel_valid_reg <= 1'b0;
			sel_last_reg  <= 1'b0;
			sel_seen_reg  <= 1'b0;
		end else begin
			sel_valid_reg <= 1'b1;
			sel_last_reg  <= select_in;
			sel_seen_reg  <= sel_seen_next;
		end
	end

	// ----------------------------------------
	// Header holding register
	// ----------------------------------------
	// Nine stages; the sync bit only opens the header and is not stored
	for (genvar g = 0; g < `SRE_HDR_BITS; g++) begin : g_hdr
		logic stage_reg;
		always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
			if (!rst_n_in)
				stage_reg <= 1'b0; // R1
			else if (hdr_clear)
				stage_reg <= 1'b0; // R8
			else if (hdr_shift)
				stage_reg <= hdr_chain[g]; // R2
		end
		assign header_bits[g] = stage_reg;
	end

	// ----------------------------------------
	// Read buffer
	// ----------------------------------------
	sre_buf u_buf (
		.sys_clk_in    (sys_clk_in),
		.rst_n_in      (rst_n_in),
		.flush_in      (1'b0),
		.in_valid_in   (rd_take),
		.in_data_in    (ram_read_data_in),
		.in_ready_out  (busy_out),
		.out_valid_out (buf_valid),
		.out_data_out  (buf_data),
		.out_ready_in  (drain_ready)
	);

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_reg  <= 1'b0;
			wstb_reg <= 1'b0;
		end else begin
			out_reg  <= out_next; // R7
			wstb_reg <= wstb_next; // R17
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign serial_data_out        = out_reg;
	// Write data is combinational, matching the OR of select and data
	assign ram_write_data_out     = select_in | serial_data_in; // R6 R12
	assign ram_address_out        = {hdr_field(header_bits, `SRE_HB_REG_LO),
		count_reg}; // R16 R9
	assign ram_select_code_out    = in_data ?
		hdr_field(header_bits, `SRE_HB_SEL_LO) : `SRE_CODE_IDLE; // R10
	assign ram_write_strobe_out   = wstb_reg;
	assign ram_chip_enable_out    = in_data; // R17
	assign backup_ram_control_out = select_in & sel_seen_reg;
endmodule
`default_nettype wire

/* File: bench/sre_host_model.sv */
// Host model: sync marker, select and serial data.
// Assumes the device samples each bit once per four clocks.
`timescale 1ns/10ps
`default_nettype none
module sre_host_model (
	// Host link
	input  wire logic sys_clk_in,
	output logic      sync_out,
	output logic      sel_out,
	output logic      dat_out
);
	logic [1:0] ph_reg = 2'h0;
	// This device has a select line of its own; others get their own lines
	initial sel_out = 1'b1;
	initial dat_out = 1'b0;
	initial sync_out = 1'b0;
	// Data moves mid bit, far from the sampling tick
	always @(negedge sys_clk_in) begin
		ph_reg <= ph_reg + 2'h1;
		sync_out <= ph_reg == 2'h3;
	end
	task automatic send_bit(input logic s, input logic d);
		@(negedge sys_clk_in iff ph_reg == 2'h1);
		sel_out <= s;
		dat_out <= d;
	endtask
	task automatic send_header(input logic rd, input logic [7:0] sr);
		send_bit(1'b1, 1'b1);
		send_bit(1'b1, rd);
		for (int i = 7; i >= 0; i--) send_bit(1'b1, sr[i]);
	endtask
endmodule
`default_nettype wire

/* File: bench/sre_core_assertions.sv */
// Port checker for the serial RAM expansion core.
// Assumes binding onto sre_core; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module sre_core_assertions (
	// Watched ports
	input wire logic                    sys_clk_in,
	input wire logic                    rst_n_in,
	input wire logic                    select_in,
	input wire logic                    serial_data_in,
	input wire sre_pkg::sre_addr_type   ram_address_out,
	input wire sre_pkg::sre_nibble_type ram_select_code_out,
	input wire logic                    ram_write_data_out,
	input wire logic                    ram_write_strobe_out,
	input wire logic                    ram_chip_enable_out,
	input wire logic                    backup_ram_control_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	wdata_or_a: assert property (ram_write_data_out == (select_in | serial_data_in))
		else $error("write data wrong");
	strobe_pulse_a: assert property (ram_write_strobe_out |=> !ram_write_strobe_out)
		else $error("strobe too long");
	strobe_ce_a: assert property (ram_write_strobe_out |-> ram_chip_enable_out)
		else $error("strobe outside sequence");
	code_idle_a: assert property (!ram_chip_enable_out |-> ram_select_code_out == 4'h0)
		else $error("select code outside sequence");
	seq_start_a: assert property ($rose(ram_chip_enable_out) |-> ram_address_out[5:0] == 6'h00)
		else $error("count not zero at start");
	seq_end_a: assert property ($fell(ram_chip_enable_out) |-> $past(ram_address_out[5:0]) == 6'h3f)
		else $error("sequence ended early");
	// Upper bits must hold while the counter steps by one
	count_step_a: assert property (ram_chip_enable_out && $past(ram_chip_enable_out)
		&& $changed(ram_address_out) |-> ram_address_out == $past(ram_address_out) + 10'h001)
		else $error("address step wrong");
	bit_time_a: assert property ($changed(ram_address_out) && ram_chip_enable_out
		|=> (!ram_chip_enable_out || $stable(ram_address_out))[*3])
		else $error("address stepped too fast");
	bkup_sel_a: assert property (backup_ram_control_out |-> select_in)
		else $error("backup control without select");
	cover property ($fell(ram_chip_enable_out));
	cover property (ram_write_strobe_out);
	cover property ($rose(backup_ram_control_out));
endmodule
bind sre_core sre_core_assertions u_chk (.sys_clk_in, .rst_n_in, .select_in, .serial_data_in,
	.ram_address_out, .ram_select_code_out, .ram_write_data_out, .ram_write_strobe_out,
	.ram_chip_enable_out, .backup_ram_control_out);
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the serial RAM expansion core.
// Assumes the host model drives the link; RAM bit is address parity.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic sync_in, select_in, serial_data_in, serial_data_out, ram_read_data_in;
	logic ram_write_strobe_out, ram_chip_enable_out, busy_out;
	sre_pkg::sre_addr_type   ram_address_out;
	sre_pkg::sre_nibble_type ram_select_code_out;
	int n_errors = 0;
	int total_checks = 0;
	int n_stb = 0;
	always #50 sys_clk_in = ~sys_clk_in;
	assign ram_read_data_in = ^ram_address_out;
	always @(posedge sys_clk_in) if (ram_write_strobe_out) n_stb++;
	sre_host_model host (.sys_clk_in, .sync_out(sync_in), .sel_out(select_in),
		.dat_out(serial_data_in));
	sre_core DUT (.sys_clk_in, .rst_n_in, .sync_in, .select_in, .serial_data_in,
		.serial_data_out, .ram_address_out, .ram_select_code_out, .ram_write_data_out(),
		.ram_read_data_in, .ram_write_strobe_out, .ram_chip_enable_out,
		.backup_ram_control_out(), .busy_out(busy_out));
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		if (n_errors == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Select never toggled since reset, so the header is ignored
	task automatic run_refused;
		chk(ram_address_out, 10'h000);
		host.send_header(1'b0, 8'h13);
		host.send_bit(1'b1, 1'b0);
		chk(ram_chip_enable_out, 1'b0);
	endtask
	task automatic run_write;
		host.send_bit(1'b0, 1'b0);
		host.send_header(1'b0, 8'h13);
		n_stb = 0;
		for (int i = 0; i < 64; i++) begin
			host.send_bit(1'b1, i[0]);
			if (i == 8) chk(ram_select_code_out, 4'h1);
			if (i == 8) chk(ram_address_out[9:6], 4'h3);
		end
		host.send_bit(1'b0, 1'b0);
		host.send_bit(1'b0, 1'b0);
		chk(n_stb[9:0], 10'h040);
		chk(ram_chip_enable_out, 1'b0);
	endtask
	task automatic run_read;
		sre_pkg::sre_addr_type p;
		sre_pkg::sre_addr_type q;
		fork
			begin
				host.send_header(1'b1, 8'h8a);
				repeat (64) host.send_bit(1'b1, 1'b0);
				host.send_bit(1'b0, 1'b0);
			end
			begin
				@(posedge ram_chip_enable_out);
				@(negedge sys_clk_in);
				chk(ram_select_code_out, 4'h8);
				// Bit read at one tick shows on the output after the next tick
				p = ram_address_out;
				repeat (4) @(negedge sys_clk_in);
				q = ram_address_out;
				repeat (62) begin
					repeat (4) @(negedge sys_clk_in);
					chk(serial_data_out, ^p);
					p = q;
					q = ram_address_out;
				end
			end
		join
		chk(ram_address_out, 10'h000);
		chk(busy_out, 1'b1);
	endtask
	initial begin
		repeat (3) @(negedge sys_clk_in);
		rst_n_in <= 1'b1;
		run_refused;
		run_write;
		run_read;
		give_verdict;
	end
	// Whole run needs under 1000 clocks
	initial begin
		repeat (5000) @(posedge sys_clk_in);
		n_errors++;
		give_verdict;
	end
endmodule
`default_nettype wire
